// ==== mbd_pkg.sv ====
// Purpose : Constants for the multiplexed BCD digit output port
// Assumes : 125 MHz system clock
// Notes   : Times kept in their own units, cycle counts derived from them
package mbd_pkg;
    // ==========================================================
    // Clock and timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int TICK_NS       = 15000;
    localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
    localparam int STROBE_NS     = 270000;
    localparam int STROBE_TICKS  = (STROBE_NS + TICK_NS / 2) / TICK_NS;
    localparam int CONV_NS       = 400000000;
    localparam int CONV_TICKS    = (CONV_NS + TICK_NS / 2) / TICK_NS;
    localparam int EOC_NS        = 7000;
    localparam int EOC_CYC       = (EOC_NS / CLK_PERIOD_NS < 1) ? 1 : EOC_NS / CLK_PERIOD_NS;
    localparam int GAP_TICKS     = 1;
    localparam int NUM_DIGITS    = 4;

    // ==========================================================
    // Range limits and leading slot coding
    localparam logic [11:0] UNDER_LIMIT = 12'h180;
    localparam int          BIT_LEAD    = 3;
    localparam int          BIT_POS     = 2;
    localparam int          BIT_OVER    = 1;
    localparam int          BIT_UNDER   = 0;
    localparam logic [3:0]  CODE_ZERO   = 4'hA;
    localparam logic [3:0]  CODE_ONE    = 4'h0;
    localparam logic [3:0]  SYNC_RESET  = 4'h0;
endpackage

// ==== mbd_sync3.sv ====
// Purpose : Three-stage synchroniser for panel levels
// Assumes : Inputs are asynchronous levels
// Notes   : A change is taken only once stages two and three agree
`timescale 1ns/1ns
module mbd_sync3 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_out;

    // ==========================================================
    // Agreement filter per bit
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_out[i] = (stage2[i] == stage3[i]) ? stage3[i] : sync_out[i];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            stage1   <= '0;
            stage2   <= '0;
            stage3   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            stage2   <= stage1;
            stage3   <= stage2;
            sync_out <= next_out;
        end
    end
endmodule

// ==== mbd_digit_out.sv ====
// Purpose : Scans four display digits once per conversion onto BCD lines
// Assumes : Reading inputs come from logic on clk; panel lines are asynchronous
// Notes   : Reading is snapshotted at scan start so data only moves between strobes
// How it works
// - Each digit strobe lasts about 270 us
// - Chosen function line high, others low
// - Decimal-point lines follow lit display points
// - BCD data aligned with strobe; sampled during strobe
// - First strobe carries leading digit, sign, range
// - Top bit high for zero, low for one
// - Second bit high positive, low negative
// - Count 180 or less sets underrange bit
// - Count above 1999 signals overrange in slot
// - Fixed leading codes; zero codes blank digit
// - One conversion and scan every 0.4 s
// - About 7 us done pulse per conversion
`timescale 1ns/1ns
module mbd_digit_out #(
    parameter int TICK_CYC   = mbd_pkg::TICK_CYC,
    parameter int CONV_TICKS = mbd_pkg::CONV_TICKS
) (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic [2:0] panel_function,
    input  wire logic [2:0] panel_point,
    input  wire logic       read_lead_one,
    input  wire logic [3:0] read_hundreds,
    input  wire logic [3:0] read_tens,
    input  wire logic [3:0] read_units,
    input  wire logic       read_negative,
    input  wire logic       read_over,
    output logic            digit_strobe_first,
    output logic            digit_strobe_second,
    output logic            digit_strobe_third,
    output logic            digit_strobe_fourth,
    output logic [3:0]      bcd_data,
    output logic            func_volt,
    output logic            func_amp,
    output logic            func_watt,
    output logic            point_lit_third,
    output logic            point_lit_fourth,
    output logic            point_lit_fifth,
    output logic            conv_done
);
    typedef enum logic [4:0] {
        ST_LOAD   = 5'h01,
        ST_GAP    = 5'h02,
        ST_STROBE = 5'h04,
        ST_HOLD   = 5'h08,
        ST_EOC    = 5'h10
    } mbd_state_t;

    mbd_state_t  state;
    mbd_state_t  next_state;
    logic [15:0] cyc_cnt;
    logic        tick;
    logic [15:0] conv_cnt;
    logic [7:0]  phase_cnt;
    logic [1:0]  digit;
    logic [15:0] eoc_cnt;
    logic [2:0]  func_sync;
    logic [2:0]  point_sync;
    logic        snap_lead;
    logic        snap_neg;
    logic        snap_over;
    logic [3:0]  snap_hund;
    logic [3:0]  snap_tens;
    logic [3:0]  snap_units;
    logic        strobe_on;
    logic        strobe_last;
    logic        conv_last;
    logic        eoc_last;
    logic        under;
    logic [3:0]  lead_code;
    logic [3:0]  digit_code;

    localparam logic [15:0] TICK_LAST   = 16'(TICK_CYC - 1);
    localparam logic [15:0] CONV_LAST   = 16'(CONV_TICKS - 1);
    localparam logic [7:0]  STROBE_LAST = 8'(mbd_pkg::STROBE_TICKS - 1);
    localparam logic [15:0] EOC_LAST    = 16'(mbd_pkg::EOC_CYC - 1);

    // ==========================================================
    // Panel levels
    mbd_sync3 #(.WIDTH(3)) u_func_sync (
        .clk      (clk),
        .srst     (srst),
        .async_in (panel_function),
        .sync_out (func_sync)
    );
    mbd_sync3 #(.WIDTH(3)) u_point_sync (
        .clk      (clk),
        .srst     (srst),
        .async_in (panel_point),
        .sync_out (point_sync)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            {func_watt, func_amp, func_volt}                      <= 3'h0;
            {point_lit_fifth, point_lit_fourth, point_lit_third} <= 3'h0;
        end else begin
            {func_watt, func_amp, func_volt}                      <= func_sync;
            {point_lit_fifth, point_lit_fourth, point_lit_third} <= point_sync;
        end
    end

    // ==========================================================
    // Leading slot and digit selection
    function automatic logic under_check(input logic lead, input logic [3:0] h,
                                         input logic [3:0] t, input logic [3:0] u);
        under_check = !lead && ({h, t, u} <= mbd_pkg::UNDER_LIMIT);
    endfunction

    assign under = under_check(snap_lead, snap_hund, snap_tens, snap_units);

    always_comb begin
        lead_code = snap_lead ? mbd_pkg::CODE_ONE : mbd_pkg::CODE_ZERO;
        lead_code[mbd_pkg::BIT_LEAD]  = !snap_lead;
        lead_code[mbd_pkg::BIT_POS]   = !snap_neg;
        lead_code[mbd_pkg::BIT_UNDER] = under && !snap_over;
        if (snap_over) begin
            lead_code[mbd_pkg::BIT_LEAD] = 1'b0;
            lead_code[mbd_pkg::BIT_OVER] = 1'b1;
        end
    end

    assign digit_code = (digit == 2'd0) ? lead_code :
                        (digit == 2'd1) ? snap_hund :
                        (digit == 2'd2) ? snap_tens : snap_units;

    // ==========================================================
    // Tick and counters
    assign tick        = (cyc_cnt == TICK_LAST);
    assign strobe_last = tick && (phase_cnt == STROBE_LAST);
    assign conv_last   = tick && (conv_cnt == CONV_LAST);
    assign eoc_last    = (eoc_cnt == EOC_LAST);
    assign strobe_on   = (state == ST_STROBE);

    always_ff @(posedge clk) begin
        if (srst || tick) begin
            cyc_cnt <= 16'h0000;
        end else begin
            cyc_cnt <= cyc_cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || state == ST_LOAD) begin
            conv_cnt <= 16'h0000;
        end else if (tick) begin
            conv_cnt <= conv_cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || state != ST_STROBE) begin
            phase_cnt <= 8'h00;
        end else if (tick) begin
            phase_cnt <= phase_cnt + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || state != ST_EOC) begin
            eoc_cnt <= 16'h0000;
        end else begin
            eoc_cnt <= eoc_cnt + 16'h0001;
        end
    end

    // ==========================================================
    // Scan sequencer
    always_comb begin
        case (state)
            ST_LOAD:   next_state = ST_GAP;
            ST_GAP:    next_state = tick ? ST_STROBE : ST_GAP;
            ST_STROBE: next_state = !strobe_last ? ST_STROBE :
                                    (digit == 2'd3) ? ST_HOLD : ST_GAP;
            ST_HOLD:   next_state = conv_last ? ST_EOC : ST_HOLD;
            ST_EOC:    next_state = eoc_last ? ST_LOAD : ST_EOC;
            default:   next_state = ST_LOAD;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= ST_LOAD;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || state == ST_LOAD) begin
            digit <= 2'd0;
        end else if (state == ST_STROBE && strobe_last) begin
            digit <= digit + 2'd1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            {snap_lead, snap_neg, snap_over} <= 3'h0;
            {snap_hund, snap_tens, snap_units} <= 12'h000;
        end else if (state == ST_LOAD) begin
            {snap_lead, snap_neg, snap_over} <= {read_lead_one, read_negative, read_over};
            {snap_hund, snap_tens, snap_units} <= {read_hundreds, read_tens, read_units};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            bcd_data <= mbd_pkg::SYNC_RESET;
        end else if (state == ST_GAP && tick) begin
            bcd_data <= digit_code;
        end
    end

    assign digit_strobe_first  = strobe_on && (digit == 2'd0);
    assign digit_strobe_second = strobe_on && (digit == 2'd1);
    assign digit_strobe_third  = strobe_on && (digit == 2'd2);
    assign digit_strobe_fourth = strobe_on && (digit == 2'd3);
    assign conv_done           = (state == ST_EOC);

    // ==========================================================
    // Checks
    localparam int STROBE_CYC = mbd_pkg::STROBE_TICKS * TICK_CYC;
    logic [31:0] hi_cnt;
    logic [31:0] eoc_hi_cnt;
    logic [3:0]  strobes;
    assign strobes = {digit_strobe_fourth, digit_strobe_third, digit_strobe_second,
                      digit_strobe_first};

    always_ff @(posedge clk) begin
        hi_cnt     <= strobe_on ? hi_cnt + 32'd1 : 32'd0;
        eoc_hi_cnt <= conv_done ? eoc_hi_cnt + 32'd1 : 32'd0;
    end

    property p_strobe_width;
        @(posedge clk) disable iff (srst) $fell(strobe_on) |-> hi_cnt == 32'(STROBE_CYC);
    endproperty
    a_strobe_width: assert property (p_strobe_width) else $error("strobe width wrong");

    property p_onehot;
        @(posedge clk) disable iff (srst) $onehot0(strobes);
    endproperty
    a_onehot: assert property (p_onehot) else $error("strobes not one-hot");

    property p_data_stable;
        @(posedge clk) disable iff (srst) strobe_on && $past(strobe_on) |-> $stable(bcd_data);
    endproperty
    a_data_stable: assert property (p_data_stable) else $error("data moved in strobe");

    // Last strobe seen, so every new strobe is held against the successor of the last one
    logic [3:0] prev_sel;
    logic [3:0] exp_sel;

    always_ff @(posedge clk) begin
        if (srst) begin
            prev_sel <= 4'h0;
        end else if (strobes != 4'h0) begin
            prev_sel <= strobes;
        end
    end

    assign exp_sel = (prev_sel == 4'h0 || prev_sel == 4'h8) ? 4'h1 : {prev_sel[2:0], 1'b0};

    property p_order;
        @(posedge clk) disable iff (srst) $rose(strobe_on) |-> strobes == exp_sel;
    endproperty
    a_order: assert property (p_order) else $error("strobe order wrong");

    property p_func;
        @(posedge clk) disable iff (srst) ##1 {func_watt, func_amp, func_volt} == $past(func_sync);
    endproperty
    a_func: assert property (p_func) else $error("function line mismatch");

    property p_point;
        @(posedge clk) disable iff (srst)
            ##1 {point_lit_fifth, point_lit_fourth, point_lit_third} == $past(point_sync);
    endproperty
    a_point: assert property (p_point) else $error("point line mismatch");

    property p_lead;
        @(posedge clk) disable iff (srst) digit_strobe_first && !snap_over |->
            bcd_data[3] == !snap_lead && bcd_data[2] == !snap_neg;
    endproperty
    a_lead: assert property (p_lead) else $error("leading slot sign or digit wrong");

    property p_under;
        @(posedge clk) disable iff (srst) digit_strobe_first && !snap_over && !snap_lead
            && {snap_hund, snap_tens, snap_units} <= 12'h180 |-> bcd_data[0];
    endproperty
    a_under: assert property (p_under) else $error("underrange bit missing");

    property p_zero_code;
        @(posedge clk) disable iff (srst) digit_strobe_first && !snap_over && !snap_lead
            |-> bcd_data[3:1] == {1'b1, !snap_neg, 1'b1};
    endproperty
    a_zero_code: assert property (p_zero_code) else $error("zero code wrong");

    property p_over;
        @(posedge clk) disable iff (srst) digit_strobe_first && snap_over
            |-> !bcd_data[3] && bcd_data[1];
    endproperty
    a_over: assert property (p_over) else $error("overrange code wrong");

    property p_eoc;
        @(posedge clk) disable iff (srst) $fell(conv_done) |-> eoc_hi_cnt == 32'(mbd_pkg::EOC_CYC);
    endproperty
    a_eoc: assert property (p_eoc) else $error("done pulse width wrong");

    c_fourth: cover property (@(posedge clk) disable iff (srst) $fell(digit_strobe_fourth));
    c_done:   cover property (@(posedge clk) disable iff (srst) $fell(conv_done));
    c_over:   cover property (@(posedge clk) disable iff (srst) digit_strobe_first && snap_over);
endmodule

// ==== mbd_capture.sv ====
// Purpose : Capture logic on the far side of the BCD digit output port
// Assumes : Strobes and data come from logic on the same clk
// Notes   : Captured word packs leading code, hundreds, tens, units
`timescale 1ns/1ns
module mbd_capture (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        s1,
    input  wire logic        s2,
    input  wire logic        s3,
    input  wire logic        s4,
    input  wire logic [3:0]  bcd_data,
    input  wire logic        conv_done,
    output logic      [15:0] cap_word,
    output logic      [15:0] cap_width,
    output logic      [15:0] done_width,
    output logic      [15:0] conv_period,
    output logic             scan_done,
    output logic             seq_bad
);
    // ==========================================================
    // Strobe and done tracking
    logic [3:0]  sel_q;
    logic [3:0]  held;
    logic [1:0]  idx;
    logic [15:0] wcnt;
    logic [15:0] dcnt;
    logic [15:0] pcnt;
    logic        seen;
    logic        done_q;
    wire  [3:0]  sel  = {s4, s3, s2, s1};
    wire         rise = (sel != 4'h0) && (sel_q == 4'h0);
    wire         fall = (sel == 4'h0) && (sel_q != 4'h0);

    always_ff @(posedge clk) begin
        if (srst) begin
            {sel_q, held, idx, wcnt, dcnt, pcnt, seen, done_q} <= '0;
            {cap_word, cap_width, done_width, conv_period, scan_done, seq_bad} <= '0;
        end else begin
            sel_q     <= sel;
            done_q    <= conv_done;
            scan_done <= 1'b0;
            pcnt      <= pcnt + 16'h1;
            if ($countones(sel) > 1 || (conv_done && sel != 4'h0)) seq_bad <= 1'b1;
            if (rise) begin
                held <= bcd_data;
                wcnt <= 16'h1;
                if (sel != (4'h1 << idx)) seq_bad <= 1'b1;
            end else if (sel != 4'h0) begin
                wcnt <= wcnt + 16'h1;
                if (bcd_data !== held) seq_bad <= 1'b1;
            end
            if (fall) begin
                cap_width <= wcnt;
                cap_word  <= {cap_word[11:0], held};
                idx       <= idx + 2'h1;
                if (idx == 2'h3) scan_done <= 1'b1;
            end
            if (conv_done) dcnt <= dcnt + 16'h1;
            if (conv_done && !done_q) begin
                pcnt <= 16'h1;
                seen <= 1'b1;
                if (seen) conv_period <= pcnt;
            end
            if (!conv_done && done_q) begin
                done_width <= dcnt;
                dcnt       <= 16'h0;
            end
        end
    end
endmodule

// ==== mbd_digit_out_tb.sv ====
// Purpose : Self-checking bench for the multiplexed BCD digit output port
// Assumes : Shortened tick and conversion counts
// Notes   : Readings change only while the done pulse or reset is high
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin errors++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, gt); end end
module mbd_digit_out_tb;
    localparam int TC = 4;
    localparam int CT = 120;
    localparam int PER_LO = (CT - 1) * TC + mbd_pkg::EOC_CYC;
    localparam int PER_HI = (CT + 1) * TC + mbd_pkg::EOC_CYC + 2;
    localparam logic [15:0] EOC_EXP = 16'(mbd_pkg::EOC_CYC);
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [2:0]  pf = 3'h0;
    logic [2:0]  pp = 3'h0;
    logic        lead = 1'b0;
    logic        neg = 1'b0;
    logic        over = 1'b0;
    logic [3:0]  h = 4'h0;
    logic [3:0]  t = 4'h0;
    logic [3:0]  u = 4'h0;
    logic        s1, s2, s3, s4, fv, fa, fw, p3, p4, p5, done, scan_done, seq_bad;
    logic [3:0]  bcd;
    logic [15:0] cap_word, cap_width, done_width, conv_period;
    int          errors = 0;
    int          n_checks = 0;
    logic [15:0] exq[$];
    logic [15:0] exp_w;
    wire         per_ok = conv_period >= 16'(PER_LO) && conv_period <= 16'(PER_HI);
    int          rl[6][6] = '{'{0,0,0,0,0,0}, '{0,1,8,0,0,0}, '{0,1,8,1,1,0}, '{1,0,0,0,1,0},
                              '{0,0,0,0,1,0}, '{1,2,3,4,1,1}};

    always #4 clk = ~clk;

    mbd_digit_out #(.TICK_CYC(TC), .CONV_TICKS(CT)) mbd_digit_out_inst (
        .clk(clk), .srst(srst), .panel_function(pf), .panel_point(pp),
        .read_lead_one(lead), .read_hundreds(h), .read_tens(t), .read_units(u),
        .read_negative(neg), .read_over(over), .digit_strobe_first(s1),
        .digit_strobe_second(s2), .digit_strobe_third(s3), .digit_strobe_fourth(s4),
        .bcd_data(bcd), .func_volt(fv), .func_amp(fa), .func_watt(fw),
        .point_lit_third(p3), .point_lit_fourth(p4), .point_lit_fifth(p5), .conv_done(done));

    mbd_capture mbd_capture_inst (
        .clk(clk), .srst(srst), .s1(s1), .s2(s2), .s3(s3), .s4(s4), .bcd_data(bcd),
        .conv_done(done), .cap_word(cap_word), .cap_width(cap_width),
        .done_width(done_width), .conv_period(conv_period), .scan_done(scan_done),
        .seq_bad(seq_bad));

    // ==========================================================
    // Reference model of the scanned word
    function automatic logic [15:0] model(int ld, int hh, int tt, int uu, int ng, int ov);
        int         cnt;
        logic [3:0] code;
        cnt = ld * 1000 + hh * 100 + tt * 10 + uu;
        if (ov != 0) code = {1'b0, ng == 0, 2'b10};
        else if (ld != 0) code = {1'b0, ng == 0, 2'b00};
        else code = {1'b1, ng == 0, 1'b1, cnt <= 180};
        return {code, 4'(hh), 4'(tt), 4'(uu)};
    endfunction

    task automatic set_reading(int ld, int hh, int tt, int uu, int ng, int ov);
        @(negedge clk);
        {lead, neg, over} = {ld[0], ng[0], ov[0]};
        {h, t, u} = {4'(hh), 4'(tt), 4'(uu)};
        exq.push_back(model(ld, hh, tt, uu, ng, ov));
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic wait_for(bit on_scan);
        for (int i = 0; i < 4000; i++) begin
            @(negedge clk);
            if (on_scan ? scan_done === 1'b1 : done === 1'b1) return;
        end
        errors++;
        $display("[FAIL] wait expired");
        complete_run();
    endtask

    task automatic panel_chk();
        @(negedge clk);
        pf = 3'h1 << ($urandom % 3);
        pp = 3'($urandom);
        repeat (8) @(negedge clk);
        `CHK("function", pf, {fw, fa, fv})
        `CHK("points", pp, {p5, p4, p3})
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'h1D870BF3));
        set_reading(rl[0][0], rl[0][1], rl[0][2], rl[0][3], rl[0][4], rl[0][5]);
        repeat (7) @(negedge clk);
        srst = 1'b0;
        for (int k = 0; k < 8; k++) begin
            panel_chk();
            wait_for(1);
            exp_w = exq.pop_front();
            `CHK("lead digit sign", exp_w[15:14], cap_word[15:14])
            `CHK("lead range", exp_w[13:12], cap_word[13:12])
            `CHK("digits", exp_w[11:0], cap_word[11:0])
            `CHK("strobe width", 16'(mbd_pkg::STROBE_TICKS * TC), cap_width)
            `CHK("sequence", 1'b0, seq_bad)
            if (done_width != 16'h0) `CHK("done width", EOC_EXP, done_width)
            if (conv_period != 16'h0) `CHK("period", 1'b1, per_ok)
            if (k == 3) begin
                srst = 1'b1;
                exq.delete();
                set_reading(rl[4][0], rl[4][1], rl[4][2], rl[4][3], rl[4][4], rl[4][5]);
                repeat (2) @(negedge clk);
                `CHK("reset strobes", 5'h00, {s1, s2, s3, s4, done})
                `CHK("reset lines", 10'h000, {bcd, fv, fa, fw, p3, p4, p5})
                srst = 1'b0;
            end else begin
                wait_for(0);
                if (k < 3) set_reading(rl[k+1][0], rl[k+1][1], rl[k+1][2], rl[k+1][3],
                                       rl[k+1][4], rl[k+1][5]);
                else if (k == 4) set_reading(rl[5][0], rl[5][1], rl[5][2], rl[5][3],
                                             rl[5][4], rl[5][5]);
                else set_reading($urandom % 2, $urandom % 10, $urandom % 10, $urandom % 10,
                                 $urandom % 2, 0);
            end
        end
        complete_run();
    end
endmodule
